// [dv/cpm_bus_master.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Bus side partner: issues classic single cycles.
// ------------------------------------------------------------
module cpm_bus_master (
	input  wire logic        clk_sys,
	input  wire logic        ack,
	input  wire logic [31:0] rdat,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      wdat
);
	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
	end

	// Released address and data lines show inverted values so a stale sample cannot pass.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] r, output bit ok);
		int n;
		@(posedge clk_sys);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
		ok = 1'b0;
		r = 32'h0;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge clk_sys);
			if (ack === 1'b1) begin
				ok = 1'b1;
				r = rdat;
			end
		end
		{cyc, stb, we, adr, wdat} <= {3'b000, ~a, ~d};
		@(negedge clk_sys);
	endtask : xfer
endmodule : cpm_bus_master

// [dv/cpm_prog_model_properties.sv]
`timescale 1ns/1ps

`include "cpm_consts.svh"

// ------------------------------------------------------------
// Port checker for the programmer model block.
// ------------------------------------------------------------
module cpm_prog_model_checker
	import cpm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_sys,
	input wire logic              nrst,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0]        wb_sel_i,
	input wire logic [31:0]       wb_dat_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire cpm_word_t         double_accum,
	input wire cpm_word_t         eff_addr,
	input wire logic              stop_disable,
	input wire logic              irq_mask_sec,
	input wire logic              irq_mask_pri
);
	// Decoded bus events; a taken request is one not already answered.
	logic req, wreq, hit_flg, hit_acc, hit_agn, agn_ack;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wreq = req && wb_we_i;
	assign hit_flg = wb_adr_i == ADDR_W'(`CPM_OFF_FLAGS);
	assign hit_acc = wb_adr_i == ADDR_W'(`CPM_OFF_ACCUM);
	assign hit_agn = wb_adr_i == ADDR_W'(`CPM_OFF_AGEN_CTRL);
	assign agn_ack = wb_ack_o && wb_we_i && hit_agn;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_ack_latency: assert property (req |=> wb_ack_o) else $error("ack not one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
	a_flag_pins: assert property (wreq && hit_flg && wb_sel_i[0] |=> ##1
		{stop_disable, irq_mask_sec, irq_mask_pri} ==
		{$past(wb_dat_i[7]), $past(wb_dat_i[6]), $past(wb_dat_i[4])}) else $error("flag pins wrong");
	a_flag_read: assert property (wb_ack_o && !wb_we_i && hit_flg |-> wb_dat_o[7] == stop_disable
		&& wb_dat_o[6] == irq_mask_sec && wb_dat_o[4] == irq_mask_pri) else $error("flag read mismatch");
	a_accum_full: assert property (wreq && hit_acc && wb_sel_i[1:0] == 2'b11 |=> ##1
		double_accum == $past(wb_dat_i[15:0])) else $error("double accumulator load wrong");
	a_accum_lane: assert property (wreq && hit_acc && wb_sel_i[1:0] == 2'b01 |=> ##1
		double_accum == {$past(double_accum[15:8], 2), $past(wb_dat_i[7:0])})
		else $error("low lane write disturbed high byte");
	a_direct_ea: assert property (wreq && hit_agn && wb_dat_i[1:0] == 2'b00 |=> ##1
		eff_addr == {8'h00, $past(wb_dat_i[15:8])}) else $error("direct address wrong");
	a_ea_cause: assert property (!$stable(eff_addr) |-> $past(agn_ack))
		else $error("address changed without a request");

	c_flag_wr: cover property (wreq && hit_flg);
	c_direct: cover property (wreq && hit_agn && wb_dat_i[1:0] == 2'b00);
	c_lane: cover property (wreq && hit_acc && wb_sel_i[1:0] == 2'b01);
	c_branch: cover property (wreq && hit_agn && wb_dat_i[1:0] == 2'b11 && wb_dat_i[16]);
endmodule : cpm_prog_model_checker

bind cpm_prog_model cpm_prog_model_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys),
	.nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .double_accum(double_accum), .eff_addr(eff_addr),
	.stop_disable(stop_disable), .irq_mask_sec(irq_mask_sec), .irq_mask_pri(irq_mask_pri));

// [dv/testbench.sv]
`timescale 1ns/1ps

module testbench;
	import cpm_pkg::*;
	typedef struct {logic [31:0] exp; logic [31:0] msk; string name;} cpm_note_t;
	logic        clk_sys, nrst, cyc, stb, we, ack, stp, xm, im;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	cpm_word_t   dacc, ea;
	int          n_fail, check_count;
	cpm_note_t   notes[$];
	cpm_note_t   nt;

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	cpm_prog_model #(.ADDR_W(8)) u_cpm_prog_model (.clk_sys(clk_sys), .nrst(nrst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .double_accum(dacc),
		.eff_addr(ea), .stop_disable(stp), .irq_mask_sec(xm), .irq_mask_pri(im));
	cpm_bus_master u_cpm_bus_master (.clk_sys(clk_sys), .ack(ack), .rdat(rdat), .cyc(cyc),
		.stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat));

	task automatic check(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results;
		if (n_fail == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results

	// A transfer that never gets its answer ends the run.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		bit ok;
		logic [31:0] r;
		u_cpm_bus_master.xfer(w, a, s, d, r, ok);
		if (!ok) begin
			n_fail++;
			results();
		end
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		xfer(1'b1, a, s, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input string n);
		notes.push_back(cpm_note_t'{e, m, n});
		xfer(1'b0, a, 4'hf, 32'h0);
	endtask : rd

	// Every read answer retires the oldest note.
	always @(posedge clk_sys) begin
		if (ack === 1'b1 && we === 1'b0) begin
			nt = notes.pop_front();
			check(nt.name, rdat & nt.msk, nt.exp & nt.msk);
		end
	end

	initial begin
		logic [15:0] x, y, pc, w, sp;
		logic [7:0]  op, m, h;
		logic [31:0] d;
		cpm_word_t   e;
		int          i;
		nrst = 1'b0;
		n_fail = 0;
		check_count = 0;
		void'($urandom(32'h576b1f15));
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		// Reset values, a read-only place and an unmapped hole.
		rd(8'h04, 32'hd0, 32'hff, "flags_rst");
		rd(8'h1c, 32'h0001_0000, '1, "agen_rst");
		check("pins_rst", 32'({stp, xm, im}), 32'h7);
		wr(8'h44, 4'hf, $urandom);
		rd(8'h44, 32'h0, '1, "hole");
		// Walk one set bit through the flag register.
		for (i = 0; i < 8; i++) begin
			d = 32'h1 << i;
			wr(8'h04, 4'h1, d);
			rd(8'h04, d, 32'hff, "flags");
			check("flag_pins", 32'({stp, xm, im}), 32'({d[7], d[6], d[4]}));
		end
		// Accumulators: full load, then the low lane alone.
		d = $urandom;
		h = $urandom;
		wr(8'h00, 4'h3, d);
		wr(8'h00, 4'h1, {d[31:16], ~d[15:8], h});
		check("dacc", 32'(dacc), {16'h0, d[15:8], h});
		rd(8'h00, {16'h0, d[15:8], h}, 32'hffff, "accum");
		// Sixteen-bit registers, high byte written alone.
		for (i = 0; i < 4; i++) begin
			w = $urandom;
			h = $urandom;
			wr(8'h08 + 8'(4 * i), 4'h3, 32'(w));
			wr(8'h08 + 8'(4 * i), 4'h2, {16'h0, h, ~w[7:0]});
			rd(8'h08 + 8'(4 * i), {16'h0, h, w[7:0]}, 32'hffff, "word");
		end
		// Operand addresses in each mode with boundary offsets.
		x = $urandom;
		y = $urandom;
		pc = $urandom;
		wr(8'h08, 4'h3, 32'(x));
		wr(8'h0c, 4'h3, 32'(y));
		wr(8'h14, 4'h3, 32'(pc));
		for (i = 0; i < 5; i++) begin
			op = (i == 3) ? 8'h80 : (i == 4) ? 8'h7f : (i == 1) ? 8'hff : 8'($urandom);
			case (i)
				0: e = {8'h00, op};
				1: e = x + 16'(op);
				2: e = y + 16'(op);
				default: e = pc + {{8{op[7]}}, op};
			endcase
			wr(8'h18, 4'hf, {15'h0, i == 4, op, 6'h0, 2'(i > 2 ? 3 : i)});
			rd(8'h1c, {e + 16'h1, e}, '1, "agen");
			check("ea", 32'(ea), 32'(e));
		end
		rd(8'h14, 32'(e), 32'hffff, "branch_pc");
		wr(8'h1c, 4'hf, 32'h0);
		rd(8'h1c, {e + 16'h1, e}, '1, "agen_ro");
		// Bit operations touch only masked bits.
		for (i = 0; i < 6; i++) begin
			op = $urandom;
			m = (i < 2) ? 8'hff : 8'($urandom);
			wr(8'h20, 4'hf, {15'h0, i[0], m, op});
			rd(8'h24, 32'(i[0] ? op | m : op & ~m), 32'hff, "bit");
		end
		// Push, pull, then both asked at once.
		sp = $urandom;
		wr(8'h10, 4'h3, 32'(sp));
		wr(8'h28, 4'h1, 32'h1);
		rd(8'h28, 32'(sp), 32'hffff, "push_slot");
		rd(8'h10, 32'(sp - 16'h1), 32'hffff, "push_sp");
		wr(8'h28, 4'h1, 32'h2);
		rd(8'h28, 32'(sp), 32'hffff, "pull_slot");
		wr(8'h28, 4'h1, 32'h3);
		rd(8'h10, 32'(sp - 16'h1), 32'hffff, "both_sp");
		@(posedge clk_sys);
		results();
	end
endmodule : testbench

// [pkg/cpm_consts.svh]
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the bus.
// ----------------------------------------------------------------------
`define CPM_OFF_ACCUM      6'h00
`define CPM_OFF_FLAGS      6'h04
`define CPM_OFF_INDEX_X    6'h08
`define CPM_OFF_INDEX_Y    6'h0c
`define CPM_OFF_STACK      6'h10
`define CPM_OFF_PC         6'h14
`define CPM_OFF_AGEN_CTRL  6'h18
`define CPM_OFF_AGEN_RES   6'h1c
`define CPM_OFF_BIT_CTRL   6'h20
`define CPM_OFF_BIT_RES    6'h24
`define CPM_OFF_STACK_CMD  6'h28
`define CPM_DEC_W          6

// ----------------------------------------------------------------------
// Flag register bit positions.
// ----------------------------------------------------------------------
`define CPM_FLAG_STOP      7
`define CPM_FLAG_XMASK     6
`define CPM_FLAG_HALF      5
`define CPM_FLAG_IMASK     4
`define CPM_FLAG_NEG       3
`define CPM_FLAG_ZERO      2
`define CPM_FLAG_OVF       1
`define CPM_FLAG_CARRY     0

// ----------------------------------------------------------------------
// Control field positions and reset values.
// ----------------------------------------------------------------------
`define CPM_MODE_MSB       1
`define CPM_MODE_LSB       0
`define CPM_OPND_MSB       15
`define CPM_OPND_LSB       8
`define CPM_BR_TAKE        16
`define CPM_BIT_OPND_MSB   7
`define CPM_BIT_OPND_LSB   0
`define CPM_BIT_MASK_MSB   15
`define CPM_BIT_MASK_LSB   8
`define CPM_BIT_SET        16
`define CPM_STK_PUSH       0
`define CPM_STK_PULL       1
`define CPM_RST_BYTE       8'h00
`define CPM_RST_WORD       16'h0000
`define CPM_RST_FLAGS      8'hd0
`define CPM_ONE_WORD       16'h0001
`define CPM_ZERO_BYTE      8'h00

`endif

// [pkg/cpm_pkg.sv]
package cpm_pkg;

	// Operand address forming modes.
	typedef enum logic [1:0] {
		cpm_mode_direct,
		cpm_mode_index_x,
		cpm_mode_index_y,
		cpm_mode_relative
	} cpm_mode_t;

	typedef logic [7:0]  cpm_byte_t;
	typedef logic [15:0] cpm_word_t;

endpackage : cpm_pkg

// [rtl/cpm_lane_reg.sv]
`timescale 1ns/1ps

`include "cpm_consts.svh"

// Register of several byte lanes, each written on its own, with a whole load.
module cpm_lane_reg #(
	parameter int NBYTES = 2
) (
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic                  wr_en,
	input  wire logic [NBYTES-1:0]     sel,
	input  wire logic [8*NBYTES-1:0]   wdat,
	input  wire logic                  ld_en,
	input  wire logic [8*NBYTES-1:0]   ld_val,
	output logic      [8*NBYTES-1:0]   q
);

	// ----------------------------------------------------------------------
	// Elaboration check.
	// ----------------------------------------------------------------------
	generate
		if (NBYTES < 1) begin : g_bad
			$error("cpm_lane_reg needs at least one byte lane");
		end
	endgenerate

	logic [8*NBYTES-1:0] q_reg;

	// A load from the block's own logic replaces the whole value; the bus
	// never writes this register in the same cycle since it decodes
	// another offset then.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q_reg <= '0;
		end else if (ld_en) begin
			q_reg <= ld_val;
		end else if (wr_en) begin
			for (int i = 0; i < NBYTES; i++) begin
				if (sel[i]) begin
					q_reg[8*i +: 8] <= wdat[8*i +: 8];
				end
			end
		end
	end

	assign q = q_reg;

endmodule : cpm_lane_reg

// [rtl/cpm_prog_model.sv]
`timescale 1ns/1ps

`include "cpm_consts.svh"

// Contract
// [RULE1] The flag register is eight bits: stop-disable bit 7, secondary mask 6, half carry 5, primary mask 4.
// [RULE2] Its low half holds negative in bit 3, zero in bit 2, overflow in bit 1 and carry in bit 0.
// [RULE3] The double accumulator is accum_a in bits 15:8 concatenated with accum_b in bits 7:0.
// [RULE4] index_x is sixteen bits and each of its bytes can be written on its own.
// [RULE5] index_y is a second sixteen-bit index, bits 15 to 0, with separate high and low bytes.
// [RULE6] The program counter is sixteen bits, handled as a high and a low byte.
// [RULE7] stack_ptr is sixteen bits with separate bytes and addresses the slots used by push and pull.
// [RULE8] The second byte of a two-byte operand sits at the first byte's address plus one.
// [RULE9] Direct mode takes the low address byte from the instruction and forces the high byte to zero.
// [RULE10] Indexed mode zero-extends the offset byte and adds it to the chosen index register.
// [RULE11] A branch target is the address after the offset byte plus the sign-extended offset.
// [RULE12] A bit operation changes only the operand bits whose mask bits are set.
module cpm_prog_model
	import cpm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	output cpm_pkg::cpm_word_t     double_accum,
	output cpm_pkg::cpm_word_t     eff_addr,
	output logic                   stop_disable,
	output logic                   irq_mask_sec,
	output logic                   irq_mask_pri
);
	import cpm_pkg::*;

	// ----------------------------------------------------------------------
	// Elaboration check.
	// ----------------------------------------------------------------------
	generate
		if (ADDR_W < `CPM_DEC_W) begin : g_bad
			$error("cpm_prog_model needs an address of at least six bits");
		end
	endgenerate

	// ----------------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------------
	logic                   ack_reg;
	logic [31:0]            dat_o_reg;
	logic                   req;
	logic                   wr_take;
	logic                   in_range;
	logic [`CPM_DEC_W-1:0]  off;
	logic [31:0]            rd_data;

	// Only the low six address bits select a register; any higher bit set
	// is an unmapped access that still gets an answer.
	assign off      = wb_adr_i[`CPM_DEC_W-1:0];
	assign in_range = ((wb_adr_i >> `CPM_DEC_W) == '0);
	assign req      = wb_cyc_i && wb_stb_i;

	// A write lands on the same edge that the master sees ack high.
	assign wr_take  = req && wb_we_i && ack_reg && in_range;

	// Ack rises one cycle after the request and drops after one cycle; a
	// request still held then is answered again one cycle later.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !ack_reg;
		end
	end

	// Read data is caught in the request cycle and held while ack stands.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dat_o_reg <= '0;
		end else if (req && !ack_reg) begin
			dat_o_reg <= rd_data;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_o_reg;

	// ----------------------------------------------------------------------
	// Write strobes per register.
	// ----------------------------------------------------------------------
	logic wr_accum;
	logic wr_flags;
	logic wr_ix;
	logic wr_iy;
	logic wr_sp;
	logic wr_pc;
	logic wr_agen;
	logic wr_bit;
	logic wr_stk;

	assign wr_accum = wr_take && (off == `CPM_OFF_ACCUM);
	assign wr_flags = wr_take && (off == `CPM_OFF_FLAGS);
	assign wr_ix    = wr_take && (off == `CPM_OFF_INDEX_X);
	assign wr_iy    = wr_take && (off == `CPM_OFF_INDEX_Y);
	assign wr_sp    = wr_take && (off == `CPM_OFF_STACK);
	assign wr_pc    = wr_take && (off == `CPM_OFF_PC);
	assign wr_agen  = wr_take && (off == `CPM_OFF_AGEN_CTRL);
	assign wr_bit   = wr_take && (off == `CPM_OFF_BIT_CTRL);
	assign wr_stk   = wr_take && (off == `CPM_OFF_STACK_CMD);

	// ----------------------------------------------------------------------
	// Accumulators and flags.
	// ----------------------------------------------------------------------
	cpm_byte_t accum_a_reg;
	cpm_byte_t accum_b_reg;
	cpm_byte_t flag_register_reg;

	// Byte lane 1 reaches accum_a and lane 0 accum_b, so one word write
	// loads the double accumulator in its natural order.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			accum_a_reg <= `CPM_RST_BYTE;
			accum_b_reg <= `CPM_RST_BYTE;
		end else if (wr_accum) begin
			if (wb_sel_i[1]) begin
				accum_a_reg <= wb_dat_i[15:8];
			end
			if (wb_sel_i[0]) begin
				accum_b_reg <= wb_dat_i[7:0];
			end
		end
	end

	assign double_accum = {accum_a_reg, accum_b_reg}; // [RULE3]

	// Both interrupt masks and stop-disable come out of reset set, which
	// keeps the core quiet until software has prepared it.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			flag_register_reg <= `CPM_RST_FLAGS;
		end else if (wr_flags && wb_sel_i[0]) begin
			flag_register_reg <= wb_dat_i[7:0]; // [RULE1] [RULE2]
		end
	end

	// The control bits of the upper half drive the block's outputs.
	assign stop_disable = flag_register_reg[`CPM_FLAG_STOP]; // [RULE1]
	assign irq_mask_sec = flag_register_reg[`CPM_FLAG_XMASK]; // [RULE1]
	assign irq_mask_pri = flag_register_reg[`CPM_FLAG_IMASK]; // [RULE1]

	// ----------------------------------------------------------------------
	// Sixteen-bit pointer registers.
	// ----------------------------------------------------------------------
	cpm_word_t index_x_q;
	cpm_word_t index_y_q;
	cpm_word_t stack_ptr_q;
	cpm_word_t pc_q;
	logic      sp_ld;
	cpm_word_t sp_ld_val;
	logic      pc_ld;
	cpm_word_t pc_ld_val;

	// Index X, byte lanes written one by one.
	cpm_lane_reg #(
		.NBYTES (2)
	) u_index_x (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.wr_en   (wr_ix), // [RULE4]
		.sel     (wb_sel_i[1:0]),
		.wdat    (wb_dat_i[15:0]),
		.ld_en   (1'b0),
		.ld_val  (`CPM_RST_WORD),
		.q       (index_x_q)
	);

	// Index Y, same layout as X.
	cpm_lane_reg #(
		.NBYTES (2)
	) u_index_y (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.wr_en   (wr_iy), // [RULE5]
		.sel     (wb_sel_i[1:0]),
		.wdat    (wb_dat_i[15:0]),
		.ld_en   (1'b0),
		.ld_val  (`CPM_RST_WORD),
		.q       (index_y_q)
	);

	// Stack pointer, also moved by push and pull.
	cpm_lane_reg #(
		.NBYTES (2)
	) u_stack_ptr (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.wr_en   (wr_sp), // [RULE7]
		.sel     (wb_sel_i[1:0]),
		.wdat    (wb_dat_i[15:0]),
		.ld_en   (sp_ld),
		.ld_val  (sp_ld_val),
		.q       (stack_ptr_q)
	);

	// Program counter, also loaded by a taken branch.
	cpm_lane_reg #(
		.NBYTES (2)
	) u_pc (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.wr_en   (wr_pc), // [RULE6]
		.sel     (wb_sel_i[1:0]),
		.wdat    (wb_dat_i[15:0]),
		.ld_en   (pc_ld),
		.ld_val  (pc_ld_val),
		.q       (pc_q)
	);

	// ----------------------------------------------------------------------
	// Stack push and pull.
	// ----------------------------------------------------------------------
	cpm_word_t stack_slot_reg;
	logic      do_push;
	logic      do_pull;

	// A push uses the slot at the pointer and then steps down; a pull
	// steps up first and uses that slot. Asking for both at once is taken
	// as a push so the pointer never moves twice.
	assign do_push   = wr_stk && wb_sel_i[0] && wb_dat_i[`CPM_STK_PUSH];
	assign do_pull   = wr_stk && wb_sel_i[0] && wb_dat_i[`CPM_STK_PULL] && !do_push;
	assign sp_ld     = do_push || do_pull;
	assign sp_ld_val = do_push ? (stack_ptr_q - `CPM_ONE_WORD)
	                           : (stack_ptr_q + `CPM_ONE_WORD); // [RULE7]

	// Remembers the memory slot that the last push or pull touched.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stack_slot_reg <= `CPM_RST_WORD;
		end else if (do_push) begin
			stack_slot_reg <= stack_ptr_q; // [RULE7]
		end else if (do_pull) begin
			stack_slot_reg <= stack_ptr_q + `CPM_ONE_WORD; // [RULE7]
		end
	end

	// ----------------------------------------------------------------------
	// Operand address forming.
	// ----------------------------------------------------------------------
	cpm_mode_t mode_in;
	cpm_byte_t opnd_in;
	cpm_word_t ea_calc;
	cpm_word_t ea_reg;
	cpm_word_t ea_hi_reg;
	cpm_mode_t mode_reg;

	assign mode_in = cpm_mode_t'(wb_dat_i[`CPM_MODE_MSB:`CPM_MODE_LSB]);
	assign opnd_in = wb_dat_i[`CPM_OPND_MSB:`CPM_OPND_LSB];

	// The program counter is taken to hold the address that follows the
	// offset byte, so a relative target needs no further adjustment.
	always_comb begin
		case (mode_in)
			cpm_mode_direct: begin
				ea_calc = {`CPM_ZERO_BYTE, opnd_in}; // [RULE9]
			end
			cpm_mode_index_x: begin
				ea_calc = index_x_q + {`CPM_ZERO_BYTE, opnd_in}; // [RULE10]
			end
			cpm_mode_index_y: begin
				ea_calc = index_y_q + {`CPM_ZERO_BYTE, opnd_in}; // [RULE10]
			end
			cpm_mode_relative: begin
				ea_calc = pc_q + {{8{opnd_in[7]}}, opnd_in}; // [RULE11]
			end
			default: begin
				ea_calc = `CPM_RST_WORD;
			end
		endcase
	end

	// The address is caught at the write so later index changes do not
	// move an operand that is already being fetched.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ea_reg    <= `CPM_RST_WORD;
			ea_hi_reg <= `CPM_ONE_WORD;
			mode_reg  <= cpm_mode_direct;
		end else if (wr_agen) begin
			ea_reg    <= ea_calc;
			ea_hi_reg <= ea_calc + `CPM_ONE_WORD; // [RULE8]
			mode_reg  <= mode_in;
		end
	end

	// A taken relative branch moves the program counter to the target.
	assign pc_ld     = wr_agen && wb_dat_i[`CPM_BR_TAKE] && (mode_in == cpm_mode_relative);
	assign pc_ld_val = ea_calc; // [RULE11]
	assign eff_addr  = ea_reg;

	// ----------------------------------------------------------------------
	// Bit set and clear under mask.
	// ----------------------------------------------------------------------
	cpm_byte_t bit_res_reg;
	cpm_byte_t bit_opnd;
	cpm_byte_t bit_mask;

	assign bit_opnd = wb_dat_i[`CPM_BIT_OPND_MSB:`CPM_BIT_OPND_LSB];
	assign bit_mask = wb_dat_i[`CPM_BIT_MASK_MSB:`CPM_BIT_MASK_LSB];

	// Bits outside the mask pass through untouched in both directions.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bit_res_reg <= `CPM_RST_BYTE;
		end else if (wr_bit) begin
			if (wb_dat_i[`CPM_BIT_SET]) begin
				bit_res_reg <= bit_opnd | bit_mask; // [RULE12]
			end else begin
				bit_res_reg <= bit_opnd & ~bit_mask; // [RULE12]
			end
		end
	end

	// ----------------------------------------------------------------------
	// Read mux.
	// ----------------------------------------------------------------------
	// Unmapped offsets read as zero; bits above a register's width too.
	always_comb begin
		rd_data = '0;
		if (in_range) begin
			case (off)
				`CPM_OFF_ACCUM:     rd_data[15:0] = double_accum; // [RULE3]
				`CPM_OFF_FLAGS:     rd_data[7:0]  = flag_register_reg;
				`CPM_OFF_INDEX_X:   rd_data[15:0] = index_x_q;
				`CPM_OFF_INDEX_Y:   rd_data[15:0] = index_y_q;
				`CPM_OFF_STACK:     rd_data[15:0] = stack_ptr_q;
				`CPM_OFF_PC:        rd_data[15:0] = pc_q;
				`CPM_OFF_AGEN_CTRL: rd_data[1:0]  = mode_reg;
				`CPM_OFF_AGEN_RES:  rd_data       = {ea_hi_reg, ea_reg}; // [RULE8]
				`CPM_OFF_BIT_RES:   rd_data[7:0]  = bit_res_reg;
				`CPM_OFF_STACK_CMD: rd_data[15:0] = stack_slot_reg;
				default:            rd_data       = '0;
			endcase
		end
	end

endmodule : cpm_prog_model
